// >>> logic/ebrb_pkg.sv
package ebrb_pkg;
  // Address slices captured by the three latch strobes
  localparam int ADDR_W = 26;
  localparam int SLICE_HI_MSB = 25;
  localparam int SLICE_HI_LSB = 18;
  localparam int SLICE_MID_MSB = 17;
  localparam int SLICE_MID_LSB = 10;
  localparam int SLICE_LO_MSB = 9;
  localparam int SLICE_LO_LSB = 2;
  localparam int DATA_W = 8;
  // Phase timing, in clock cycles
  localparam logic [2:0] SETUP_CYC = 3'h1;
  localparam logic [2:0] STROBE_CYC = 3'h2;
  localparam logic [2:0] ACCESS_CYC = 3'h4;
  localparam logic [2:0] HOLD_CYC = 3'h1;

  typedef enum logic [3:0] {
    EBRB_IDLE = 4'h0,
    EBRB_HI_SET = 4'h1,
    EBRB_HI_LAT = 4'h2,
    EBRB_MID_SET = 4'h3,
    EBRB_MID_LAT = 4'h4,
    EBRB_LO_SET = 4'h5,
    EBRB_LO_LAT = 4'h6,
    EBRB_SEL = 4'h7,
    EBRB_ACC = 4'h8,
    EBRB_HOLD = 4'h9
  } ebrb_state_t;

  typedef struct packed {
    ebrb_state_t state;
    logic [2:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic [DATA_W-1:0] busOut;
    logic busOe;
    logic leHi;
    logic leMid;
    logic leLo;
    logic [1:0] addrLow;
    logic selN;
    logic weN;
    logic oeN;
  } ebrb_reg_t;
endpackage

// >>> logic/ebrb_ext_byte_ram_bus.sv
// Behaviour
// - Address slices go out on the data lines, each caught by a latch strobe.
// - First strobe carries A[25:18], second A[17:10], third A[9:2].
// - Address bits 1 and 0 drive two dedicated outputs directly.
// - Chip select, write strobe and read strobe are device outputs.
// - Eight shared lines carry address then one data byte per access.
// - Console uses primary pins without external RAM, alternate pins with it.
// - Reset pin is asynchronous active low.
`timescale 1ns/10ps
module ebrb_ext_byte_ram_bus (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_reset_n,
  input wire logic extRamEnable,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [ebrb_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [ebrb_pkg::DATA_W-1:0] reqWdata,
  output logic rspValid,
  output logic [ebrb_pkg::DATA_W-1:0] rspRdata,
  input wire logic [ebrb_pkg::DATA_W-1:0] extBusAdLineIn,
  output logic [ebrb_pkg::DATA_W-1:0] extBusAdLineOut,
  output logic extBusAdLineOe,
  output logic addr_slice_hi_latch,
  output logic addr_slice_mid_latch,
  output logic addr_slice_lo_latch,
  output logic addr_bit0_out,
  output logic addr_bit1_out,
  output logic ram_select_n,
  output logic ram_write_strobe_n,
  output logic ram_read_strobe_n,
  input wire logic consoleTx,
  output logic consoleRx,
  output logic console_tx_primary,
  input wire logic console_rx_primary,
  output logic console_tx_alternate,
  input wire logic console_rx_alternate,
  output logic program_enable_n
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and combined reset
  logic [1:0] arstSync;
  logic [1:0] cfgSync;
  logic [1:0] rxPriSync;
  logic [1:0] rxAltSync;
  // Shared bus pins pass two flops like the configuration, console receive and pin reset inputs
  logic [1:0][ebrb_pkg::DATA_W-1:0] busSync;
  logic resetAll;

  // Pin reset is caught asynchronously, released through two flops
  always_ff @(posedge clk or negedge async_reset_n) begin
    if (!async_reset_n) begin
      arstSync <= 2'h0;
    end else begin
      arstSync <= {arstSync[0], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    cfgSync <= {cfgSync[0], extRamEnable};
    rxPriSync <= {rxPriSync[0], console_rx_primary};
    rxAltSync <= {rxAltSync[0], console_rx_alternate};
    busSync <= {busSync[0], extBusAdLineIn};
  end

  assign resetAll = !rst_n || !arstSync[1];

  ////////////////////////////////////////////////////////////////////////
  // Console pin steering
  // Primary pair is lent to the bus once external RAM is configured
  always_comb begin
    if (cfgSync[1]) begin
      console_tx_alternate = consoleTx;
      console_tx_primary = 1'b1;
      consoleRx = rxAltSync[1];
    end else begin
      console_tx_alternate = 1'b1;
      console_tx_primary = 1'b1;
      consoleRx = rxPriSync[1];
    end
    if (!cfgSync[1]) begin
      console_tx_primary = consoleTx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  ebrb_pkg::ebrb_reg_t r_q, r_d;

  assign reqReady = (r_q.state == ebrb_pkg::EBRB_IDLE) && cfgSync[1] && !resetAll;

  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.leHi = 1'b0;
    r_d.leMid = 1'b0;
    r_d.leLo = 1'b0;
    if (r_q.cnt != 3'h0) begin
      r_d.cnt = r_q.cnt - 3'h1;
    end
    case (r_q.state)
      ebrb_pkg::EBRB_IDLE: begin
        r_d.selN = 1'b1;
        r_d.weN = 1'b1;
        r_d.oeN = 1'b1;
        r_d.busOe = 1'b0;
        if (reqValid && reqReady) begin
          r_d.addr = reqAddr;
          r_d.wdata = reqWdata;
          r_d.write = reqWrite;
          r_d.addrLow = reqAddr[1:0];
          r_d.busOut = reqAddr[ebrb_pkg::SLICE_HI_MSB:ebrb_pkg::SLICE_HI_LSB];
          r_d.busOe = 1'b1;
          r_d.cnt = ebrb_pkg::SETUP_CYC;
          r_d.state = ebrb_pkg::EBRB_HI_SET;
        end
      end
      ebrb_pkg::EBRB_HI_SET: begin
        r_d.leHi = 1'b1;
        r_d.cnt = ebrb_pkg::STROBE_CYC;
        r_d.state = ebrb_pkg::EBRB_HI_LAT;
      end
      ebrb_pkg::EBRB_HI_LAT: begin
        r_d.leHi = (r_q.cnt > 3'h1);
        if (r_q.cnt <= 3'h1) begin
          r_d.busOut = r_q.addr[ebrb_pkg::SLICE_MID_MSB:ebrb_pkg::SLICE_MID_LSB];
          r_d.state = ebrb_pkg::EBRB_MID_SET;
        end
      end
      ebrb_pkg::EBRB_MID_SET: begin
        r_d.leMid = 1'b1;
        r_d.cnt = ebrb_pkg::STROBE_CYC;
        r_d.state = ebrb_pkg::EBRB_MID_LAT;
      end
      ebrb_pkg::EBRB_MID_LAT: begin
        r_d.leMid = (r_q.cnt > 3'h1);
        if (r_q.cnt <= 3'h1) begin
          r_d.busOut = r_q.addr[ebrb_pkg::SLICE_LO_MSB:ebrb_pkg::SLICE_LO_LSB];
          r_d.state = ebrb_pkg::EBRB_LO_SET;
        end
      end
      ebrb_pkg::EBRB_LO_SET: begin
        // Always strobed; small systems may leave it unwired
        r_d.leLo = 1'b1;
        r_d.cnt = ebrb_pkg::STROBE_CYC;
        r_d.state = ebrb_pkg::EBRB_LO_LAT;
      end
      ebrb_pkg::EBRB_LO_LAT: begin
        r_d.leLo = (r_q.cnt > 3'h1);
        if (r_q.cnt <= 3'h1) begin
          // Data phase: drive for writes, release for reads
          r_d.busOut = r_q.write ? r_q.wdata : 8'h00;
          r_d.busOe = r_q.write;
          r_d.state = ebrb_pkg::EBRB_SEL;
        end
      end
      ebrb_pkg::EBRB_SEL: begin
        r_d.selN = 1'b0;
        r_d.weN = !r_q.write;
        r_d.oeN = r_q.write;
        r_d.cnt = ebrb_pkg::ACCESS_CYC;
        r_d.state = ebrb_pkg::EBRB_ACC;
      end
      ebrb_pkg::EBRB_ACC: begin
        if (r_q.cnt <= 3'h1) begin
          r_d.weN = 1'b1;
          r_d.oeN = 1'b1;
          if (!r_q.write) begin
            // Synced sample is two cycles old, taken mid-strobe while RAM drives
            r_d.rdata = busSync[1];
          end
          r_d.cnt = ebrb_pkg::HOLD_CYC;
          r_d.state = ebrb_pkg::EBRB_HOLD;
        end
      end
      ebrb_pkg::EBRB_HOLD: begin
        // Select and write data held one cycle past the strobe edge
        r_d.selN = 1'b1;
        r_d.busOe = 1'b0;
        r_d.done = 1'b1;
        r_d.state = ebrb_pkg::EBRB_IDLE;
      end
      default: begin
        r_d.state = ebrb_pkg::EBRB_IDLE;
      end
    endcase
  end

  // One synchronous reset for both sources; the pin reaches state only through its flops
  always_ff @(posedge clk) begin
    if (resetAll) begin
      r_q <= '0;
      r_q.selN <= 1'b1;
      r_q.weN <= 1'b1;
      r_q.oeN <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs
  assign extBusAdLineOut = r_q.busOut;
  assign extBusAdLineOe = r_q.busOe;
  assign addr_slice_hi_latch = r_q.leHi;
  assign addr_slice_mid_latch = r_q.leMid;
  assign addr_slice_lo_latch = r_q.leLo;
  assign addr_bit0_out = r_q.addrLow[0];
  assign addr_bit1_out = r_q.addrLow[1];
  assign ram_select_n = r_q.selN;
  assign ram_write_strobe_n = r_q.weN;
  assign ram_read_strobe_n = r_q.oeN;
  assign rspValid = r_q.done;
  assign rspRdata = r_q.rdata;
  assign program_enable_n = 1'b1;

endmodule // ebrb_ext_byte_ram_bus

// >>> sim/ebrb_asserts.sv
`timescale 1ns/10ps
module ebrb_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_reset_n,
  input wire logic extRamEnable,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic extBusAdLineOe,
  input wire logic addr_slice_hi_latch,
  input wire logic addr_slice_mid_latch,
  input wire logic addr_slice_lo_latch,
  input wire logic ram_select_n,
  input wire logic ram_write_strobe_n,
  input wire logic ram_read_strobe_n,
  input wire logic console_tx_primary
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !async_reset_n);
  rsp_time_a: assert property (reqValid && reqReady |-> ##16 rspValid) else $error("late reply");
  rsp_pulse_a: assert property (rspValid |=> !rspValid) else $error("long reply");
  hi_width_a: assert property ($rose(addr_slice_hi_latch) |=> addr_slice_hi_latch ##1 !addr_slice_hi_latch)
    else $error("hi strobe width");
  mid_order_a: assert property ($rose(addr_slice_mid_latch) |-> $past(addr_slice_hi_latch, 2))
    else $error("mid early");
  lo_order_a: assert property ($rose(addr_slice_lo_latch) |-> $past(addr_slice_mid_latch, 2))
    else $error("lo early");
  sel_after_a: assert property ($fell(ram_select_n) |-> $past(addr_slice_lo_latch, 2))
    else $error("select early");
  idle_high_a: assert property (ram_select_n |-> ram_write_strobe_n && ram_read_strobe_n)
    else $error("strobe unselected");
  read_float_a: assert property (!ram_read_strobe_n |-> !extBusAdLineOe && ram_write_strobe_n)
    else $error("bus driven on read");
  write_drive_a: assert property (!ram_write_strobe_n |-> extBusAdLineOe) else $error("bus idle on write");
  console_mux_a: assert property (extRamEnable [*5] |-> console_tx_primary) else $error("primary tx");
  ready_gate_a: assert property (!extRamEnable [*5] |-> !reqReady) else $error("ready unconfigured");
endmodule // ebrb_asserts
bind ebrb_ext_byte_ram_bus ebrb_asserts ebrb_asserts_i (.clk, .rst_n, .async_reset_n, .extRamEnable,
  .reqValid, .reqReady, .rspValid, .extBusAdLineOe, .addr_slice_hi_latch, .addr_slice_mid_latch,
  .addr_slice_lo_latch, .ram_select_n, .ram_write_strobe_n, .ram_read_strobe_n, .console_tx_primary);

// >>> sim/ebrb_ram_model.sv
`timescale 1ns/10ps
module ebrb_ram_model (
  input wire logic clk,
  input wire logic [7:0] busOut,
  input wire logic busOe,
  input wire logic leHi,
  input wire logic leMid,
  input wire logic leLo,
  input wire logic a0,
  input wire logic a1,
  input wire logic selN,
  input wire logic weN,
  input wire logic oeN,
  output logic [7:0] busIn
);
  logic [7:0] hi;
  logic [7:0] mid;
  logic [7:0] lo;
  logic [7:0] last = 8'h00;
  // Eight entries by low address bits; full address kept as a tag
  logic [7:0] mem [8];
  logic [25:0] tag [8];
  logic [25:0] addr;
  logic hit;
  assign addr = {hi, mid, lo, a1, a0};
  assign hit = (tag[addr[2:0]] === addr);
  // Latches sampled on the clock: a slice changing as its strobe falls is not caught
  always @(posedge clk) if (leHi === 1'b1) hi <= busOut;
  always @(posedge clk) if (leMid === 1'b1) mid <= busOut;
  // Third latch kept: the full address is compared against the tag
  always @(posedge clk) if (leLo === 1'b1) lo <= busOut;
  always @(posedge weN) begin
    if (selN === 1'b0) begin
      mem[addr[2:0]] <= busOut;
      tag[addr[2:0]] <= addr;
    end
  end
  // Undriven bus toggles; a wrong address reads back inverted
  assign busIn = (!selN && !oeN) ? (hit ? mem[addr[2:0]] : ~mem[addr[2:0]]) : busOe ? busOut : ~last;
  always @(posedge clk) last <= busIn;
endmodule // ebrb_ram_model

// >>> sim/ebrb_ext_byte_ram_bus_bench.sv
`timescale 1ns/10ps
module ebrb_ext_byte_ram_bus_bench;
  logic clk, rstN, asyncResetN, ramEn, reqValid, reqWrite, reqReady, rspValid, oe;
  logic cTx, cRx, txP, txA, rxP, rxA, hi, mid, lo, b0, b1, sel, we, re, pEn;
  logic [25:0] reqAddr;
  logic [7:0] reqWdata, rspRdata, busIn, busOut, dt [8];
  logic [25:0] ad [8];
  logic [8:0] notes [$];
  logic [8:0] nt;
  int n_fail = 0;
  int tests_run = 0;
  ebrb_ext_byte_ram_bus ebrb_ext_byte_ram_bus_i (.clk(clk), .rst_n(rstN), .async_reset_n(asyncResetN),
    .extRamEnable(ramEn), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata), .extBusAdLineIn(busIn),
    .extBusAdLineOut(busOut), .extBusAdLineOe(oe), .addr_slice_hi_latch(hi), .addr_slice_mid_latch(mid),
    .addr_slice_lo_latch(lo), .addr_bit0_out(b0), .addr_bit1_out(b1), .ram_select_n(sel),
    .ram_write_strobe_n(we), .ram_read_strobe_n(re), .consoleTx(cTx), .consoleRx(cRx),
    .console_tx_primary(txP), .console_rx_primary(rxP), .console_tx_alternate(txA),
    .console_rx_alternate(rxA), .program_enable_n(pEn));
  ebrb_ram_model ebrb_ram_model_i (.clk(clk), .busOut(busOut), .busOe(oe), .leHi(hi), .leMid(mid),
    .leLo(lo), .a0(b0), .a1(b1), .selN(sel), .weN(we), .oeN(re), .busIn(busIn));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic access(input logic w, input logic [25:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    reqValid = 1;
    reqWrite = w;
    reqAddr = a;
    reqWdata = d;
    notes.push_back({!w, d});
    n = 0;
    // Held until ready is seen, taken at the next rising edge
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) n_fail++;
    @(negedge clk);
    reqValid = 0;
  endtask
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      check(8'(notes.size() != 0), 8'h01);
      if (notes.size() != 0) begin
        nt = notes.pop_front();
        if (nt[8]) check(rspRdata, nt[7:0]);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    rstN = 0;
    asyncResetN = 1;
    ramEn = 1;
    reqValid = 0;
    reqWrite = 0;
    reqAddr = 0;
    reqWdata = 0;
    cTx = 1;
    rxP = 1;
    rxA = 1;
    void'($urandom(32'hc7d6));
    repeat (5) @(negedge clk);
    rstN = 1;
    for (int i = 0; i < 8; i++) begin
      ad[i] = {23'($urandom), 3'(i)};
      dt[i] = 8'($urandom);
      access(1, ad[i], dt[i]);
    end
    for (int i = 7; i >= 0; i--) access(0, ad[i], dt[i]);
    repeat (20) @(negedge clk);
    for (int m = 0; m < 2; m++) begin
      ramEn = m[0];
      // Held low so neither idle-high transmit pin can pass by chance
      cTx = 1'b0;
      rxP = 1'($urandom);
      rxA = ~rxP;
      repeat (8) @(negedge clk);
      check(8'(txP), 8'(ramEn ? 1'b1 : cTx));
      check(8'(txA), 8'(ramEn ? cTx : 1'b1));
      check(8'(cRx), 8'(ramEn ? rxA : rxP));
      check(8'(reqReady), 8'(ramEn));
    end
    asyncResetN = 0;
    repeat (2) @(negedge clk);
    check(8'(reqReady), 8'h00);
    check(8'(sel), 8'h01);
    check(8'(pEn), 8'h01);
    asyncResetN = 1;
    access(0, ad[3], dt[3]);
    repeat (30) @(negedge clk);
    check(8'(notes.size()), 8'h00);
    stop_test();
  end
endmodule // ebrb_ext_byte_ram_bus_bench
